/* inc/pcc_defs.svh */
// Constants for the clock-control register block
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH
// Printed offsets are register indices; byte address is four times
`define PCC_IDX_SRC      12'h000
`define PCC_IDX_DEN      12'h001
`define PCC_IDX_NUM      12'h002
`define PCC_IDX_CFG      12'h003
`define PCC_IDX_LOCK     12'h005
`define PCC_IDX_XTAL     12'h292
`define PCC_IDX_IRQ_STAT 12'h006
`define PCC_IDX_IRQ_MASK 12'h007
// Reset values
`define PCC_RST_SRC      16'h0001
`define PCC_RST_ZERO     16'h0000
// Field positions
`define PCC_SRC_BYPASS   0
`define PCC_CFG_EN       0
`define PCC_CFG_MODE     1
`define PCC_CFG_PRE_LO   4
`define PCC_CFG_PRE_HI   7
`define PCC_CFG_MUL_LO   11
`define PCC_CFG_MUL_HI   15
`define PCC_XTAL_MASK    16'h0003
// Writable bits of the source and loop config registers
`define PCC_SRC_MASK     16'h0001
`define PCC_CFG_MASK     16'hf8f3
// Interrupt status bits
`define PCC_IRQ_LOCK     0
`define PCC_IRQ_UNLOCK   1
`define PCC_IRQ_MASKW    16'h0003
// AXI responses
`define PCC_RESP_OKAY    2'h0
`define PCC_RESP_SLVERR  2'h2
// Lock acquisition time in ns, and its cycle count at 4 ns period
`define PCC_LOCK_NS      400
`define PCC_CLK_NS       4
`define PCC_LOCK_CYC     ((`PCC_LOCK_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)
`endif

/* inc/pcc_pkg.sv */
// Types for the clock-control register block
package pcc_pkg;
  // Loop state
  typedef enum logic [1:0] {
    PCC_OFF     = 2'b00,
    PCC_ACQUIRE = 2'b01,
    PCC_LOCKED  = 2'b10
  } pcc_loop_e;
  // Whole module state
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] den;
    logic [15:0] num;
    logic [15:0] cfg;
    logic [15:0] xtal;
    logic [15:0] irq_stat;
    logic [15:0] irq_mask;
    pcc_loop_e   loop;
    logic [15:0] lock_cnt;
    logic        aw_got;
    logic [13:0] aw_idx;
    logic        w_got;
    logic [15:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pcc_state_s;
endpackage

/* hdl/pcc_regs.sv */
// Clock-source and PLL configuration registers on AXI4-Lite
`timescale 1ns/1ps
`include "pcc_defs.svh"
module pcc_regs #(
  parameter int LOCK_CYC = `PCC_LOCK_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Write address channel
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [15:0] s_axi_awaddr,
  // Write data channel
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // Write response channel
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // Read address channel
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [15:0] s_axi_araddr,
  // Read data channel
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Clock steering outputs
  output logic             clk_sel_pin,
  output logic             pll_enable,
  output logic             pll_frac_mode,
  output logic [4:0]       pll_multiplier,
  output logic [4:0]       pll_prescale,
  output logic [15:0]      frac_numerator,
  output logic [15:0]      frac_denominator,
  output logic [1:0]       crystal_ctrl,
  output logic             pll_locked,
  // Interrupt
  output logic             irq
);

  pcc_pkg::pcc_state_s st_reg;   // Registered state
  pcc_pkg::pcc_state_s st_next;  // Next state

  logic        wr_fire;   // Both write halves present, response free
  logic        rd_fire;   // Read address taken
  logic [15:0] wmask;     // Byte enables expanded to the low half
  logic [15:0] wval;      // Merged value helper
  logic [13:0] ar_idx;    // Read register index
  logic        lock_now;  // Loop lock
  logic [15:0] irq_set;   // Events raised this cycle

  // Halves are captured apart so they may arrive in either order
  // Ready while the half is not yet captured and no response is pending
  assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign ar_idx        = s_axi_araddr[15:2];
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign lock_now      = (st_reg.loop == pcc_pkg::PCC_LOCKED);
  assign wr_fire       = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  assign wmask = {{8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};

  // Outputs straight from registers
  assign s_axi_bvalid     = st_reg.bvalid;
  assign s_axi_bresp      = st_reg.bresp;
  assign s_axi_rvalid     = st_reg.rvalid;
  assign s_axi_rdata      = st_reg.rdata;
  assign s_axi_rresp      = st_reg.rresp;
  // Pin clock when the bypass bit is one
  assign clk_sel_pin      = st_reg.src[`PCC_SRC_BYPASS];
  assign pll_enable       = st_reg.cfg[`PCC_CFG_EN];
  assign pll_frac_mode    = st_reg.cfg[`PCC_CFG_MODE];
  assign pll_multiplier   =
    st_reg.cfg[`PCC_CFG_MUL_HI:`PCC_CFG_MUL_LO];
  // Division ratio is code plus one
  assign pll_prescale     = {1'b0,
    st_reg.cfg[`PCC_CFG_PRE_HI:`PCC_CFG_PRE_LO]} + 5'h01;
  assign frac_numerator   = st_reg.num;
  assign frac_denominator = st_reg.den;
  assign crystal_ctrl     = st_reg.xtal[1:0];
  assign pll_locked       = lock_now;
  // Level interrupt; it falls when software reads status or clears the mask bit
  assign irq = |(st_reg.irq_stat & st_reg.irq_mask);

  // Next-state logic: bus slave, loop model, interrupts
  always_comb begin
    st_next = st_reg;
    wval    = 16'h0000;
    irq_set = 16'h0000;
    // Capture write halves independently
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_idx = s_axi_awaddr[15:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_got  = 1'b1;
      st_next.w_data = s_axi_wdata[15:0];
      st_next.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Commit write once both halves are in
    if (wr_fire) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = `PCC_RESP_OKAY;
      // Aliased upper index bits: refused, nothing written
      if (st_reg.aw_idx[13:12] != 2'h0) begin
        st_next.bresp = `PCC_RESP_SLVERR;
      end else begin
        unique case (st_reg.aw_idx[11:0])
          `PCC_IDX_SRC: begin
            wval = (st_reg.src & ~wmask) | (st_reg.w_data & wmask);
            st_next.src = wval & `PCC_SRC_MASK;
          end
          `PCC_IDX_DEN: begin
            st_next.den = (st_reg.den & ~wmask)
                          | (st_reg.w_data & wmask);
          end
          `PCC_IDX_NUM: begin
            st_next.num = (st_reg.num & ~wmask)
                          | (st_reg.w_data & wmask);
          end
          `PCC_IDX_CFG: begin
            // Reserved bits 10:8, 3:2 stay zero
            wval = (st_reg.cfg & ~wmask) | (st_reg.w_data & wmask);
            st_next.cfg = wval & `PCC_CFG_MASK;
          end
          `PCC_IDX_XTAL: begin
            wval = (st_reg.xtal & ~wmask) | (st_reg.w_data & wmask);
            st_next.xtal = wval & `PCC_XTAL_MASK;
          end
          `PCC_IDX_IRQ_MASK: begin
            wval = (st_reg.irq_mask & ~wmask)
                   | (st_reg.w_data & wmask);
            st_next.irq_mask = wval & `PCC_IRQ_MASKW;
          end
          // Lock and status are read-only; writes ignored
          `PCC_IDX_LOCK, `PCC_IDX_IRQ_STAT: begin
            st_next.bresp = `PCC_RESP_OKAY;
          end
          default: begin
            st_next.bresp = `PCC_RESP_SLVERR;
          end
        endcase
      end
    end
    // Loop lock model: a fixed acquisition delay after enable
    // It is a timer, not a frequency check: a bad ratio still locks
    unique case (st_reg.loop)
      pcc_pkg::PCC_OFF: begin
        st_next.lock_cnt = 16'h0000;
        if (st_reg.cfg[`PCC_CFG_EN]) begin
          st_next.loop = pcc_pkg::PCC_ACQUIRE;
        end
      end
      pcc_pkg::PCC_ACQUIRE: begin
        if (!st_reg.cfg[`PCC_CFG_EN]) begin
          st_next.loop = pcc_pkg::PCC_OFF;
        end else if (st_reg.lock_cnt == 16'(LOCK_CYC - 1)) begin
          st_next.loop = pcc_pkg::PCC_LOCKED;
          irq_set[`PCC_IRQ_LOCK] = 1'b1;
        end else begin
          st_next.lock_cnt = st_reg.lock_cnt + 16'h0001;
        end
      end
      pcc_pkg::PCC_LOCKED: begin
        // Disable drops lock at once; any change to cfg, num or den relocks
        if (!st_reg.cfg[`PCC_CFG_EN]) begin
          st_next.loop = pcc_pkg::PCC_OFF;
          irq_set[`PCC_IRQ_UNLOCK] = 1'b1;
        end else if (st_next.cfg != st_reg.cfg
                     || st_next.num != st_reg.num
                     || st_next.den != st_reg.den) begin
          st_next.loop = pcc_pkg::PCC_ACQUIRE;
          st_next.lock_cnt = 16'h0000;
          irq_set[`PCC_IRQ_UNLOCK] = 1'b1;
        end
      end
      default: begin
        st_next.loop = pcc_pkg::PCC_OFF;
      end
    endcase
    if (s_axi_rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // Read: one cycle latency; status read clears, new events win
    if (rd_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = `PCC_RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (ar_idx[13:12] != 2'h0) begin
        st_next.rresp = `PCC_RESP_SLVERR;
      end else begin
        unique case (ar_idx[11:0])
          `PCC_IDX_SRC:  st_next.rdata = {16'h0000, st_reg.src};
          `PCC_IDX_DEN:  st_next.rdata = {16'h0000, st_reg.den};
          `PCC_IDX_NUM:  st_next.rdata = {16'h0000, st_reg.num};
          `PCC_IDX_CFG:  st_next.rdata = {16'h0000, st_reg.cfg};
          `PCC_IDX_XTAL: st_next.rdata = {16'h0000, st_reg.xtal};
          // Lock reflects live loop state, zero when disabled
          `PCC_IDX_LOCK: begin
            st_next.rdata = {31'h0000_0000, lock_now};
          end
          `PCC_IDX_IRQ_MASK: begin
            st_next.rdata = {16'h0000, st_reg.irq_mask};
          end
          `PCC_IDX_IRQ_STAT: begin
            st_next.rdata = {16'h0000, st_reg.irq_stat};
            // Clear what was returned; fresh events merge below
            st_next.irq_stat = 16'h0000;
          end
          default: st_next.rresp = `PCC_RESP_SLVERR;
        endcase
      end
    end
    // Set beats a clear in the same cycle, so no event is lost
    st_next.irq_stat = st_next.irq_stat | irq_set;
  end

  // Unlisted fields (bus flags, status, mask) clear to zero
  // State register with synchronous reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg          <= '0;
      st_reg.src      <= `PCC_RST_SRC;
      st_reg.den      <= `PCC_RST_ZERO;
      st_reg.num      <= `PCC_RST_ZERO;
      st_reg.cfg      <= `PCC_RST_ZERO;
      st_reg.loop     <= pcc_pkg::PCC_OFF;
    end else begin
      st_reg <= st_next;
    end
  end

  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  lock_needs_en_a: assert property (
    pll_locked |-> pll_enable)
    else $error("lock seen while loop disabled");
  lock_delay_a: assert property (
    $rose(pll_locked) |-> $past(pll_enable, 2))
    else $error("lock rose without prior enable");
  // Register write paths reach select, prescale, multiplier, mode, numerator and denominator; both responses and irq level
  src_sel_a: assert property (
    wr_fire && st_reg.aw_idx == {2'h0, `PCC_IDX_SRC} && st_reg.w_strb[0]
    |=> clk_sel_pin == $past(st_reg.w_data[0]))
    else $error("clock select not written");
  prescale_a: assert property (
    wr_fire && st_reg.aw_idx == {2'h0, `PCC_IDX_CFG} && st_reg.w_strb[0]
    |=> pll_prescale == {1'b0, $past(st_reg.w_data[7:4])} + 5'h01)
    else $error("prescale not code plus one");
  mult_a: assert property (
    wr_fire && st_reg.aw_idx == {2'h0, `PCC_IDX_CFG} && st_reg.w_strb[1]
    |=> pll_multiplier == $past(st_reg.w_data[15:11]))
    else $error("multiplier field misplaced");
  mode_a: assert property (
    wr_fire && st_reg.aw_idx == {2'h0, `PCC_IDX_CFG} && st_reg.w_strb[0]
    |=> pll_frac_mode == $past(st_reg.w_data[1]))
    else $error("mode bit misplaced");
  wr_resp_a: assert property (
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
  reg_write_a: assert property (
    wr_fire && st_reg.aw_idx == 14'h0001 && st_reg.w_strb[1:0] == 2'h3
    |=> frac_denominator == $past(st_reg.w_data))
    else $error("denominator not written");
  num_write_a: assert property (
    wr_fire && st_reg.aw_idx == 14'h0002 && st_reg.w_strb[1:0] == 2'h3
    |=> frac_numerator == $past(st_reg.w_data))
    else $error("numerator not written");
  rd_resp_a: assert property (
    rd_fire |=> s_axi_rvalid)
    else $error("read response missing");
  irq_lvl_a: assert property (
    irq == |(st_reg.irq_stat & st_reg.irq_mask))
    else $error("irq level wrong");

  // Lock model and its interrupt flags
  lock_wait_a: assert property (
    $rose(pll_locked) |-> $past(pll_enable, LOCK_CYC))
    else $error("lock rose before acquisition time");
  acq_bound_a: assert property (
    st_reg.loop == pcc_pkg::PCC_ACQUIRE
    |-> st_reg.lock_cnt < 16'(LOCK_CYC))
    else $error("acquisition counter overran");
  gain_flag_a: assert property (
    $rose(pll_locked) |-> st_reg.irq_stat[`PCC_IRQ_LOCK])
    else $error("lock gain not flagged");
  loss_flag_a: assert property (
    $fell(pll_locked) |-> st_reg.irq_stat[`PCC_IRQ_UNLOCK])
    else $error("lock loss not flagged");

  // Bus answers
  lock_rd_a: assert property (
    rd_fire && ar_idx == {2'h0, `PCC_IDX_LOCK}
    |=> s_axi_rdata == {31'h0000_0000, $past(pll_locked)})
    else $error("lock bit read back wrong");
  lock_ro_a: assert property (
    wr_fire && st_reg.aw_idx == {2'h0, `PCC_IDX_LOCK}
    |=> s_axi_bresp == `PCC_RESP_OKAY)
    else $error("read-only write not accepted");
  slverr_a: assert property (
    wr_fire && st_reg.aw_idx == 14'h0004 |=> s_axi_bresp == `PCC_RESP_SLVERR)
    else $error("unmapped write not refused");
  bvalid_one_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rvalid_one_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  stat_clear_a: assert property (
    rd_fire && ar_idx == {2'h0, `PCC_IDX_IRQ_STAT}
    |=> (st_reg.irq_stat & $past(st_reg.irq_stat) & ~$past(irq_set))
        == 16'h0000)
    else $error("status read did not clear");

  // Reserved bits never hold ones
  src_resv_a: assert property (
    (st_reg.src & ~`PCC_SRC_MASK) == 16'h0000)
    else $error("source reserved bits set");
  cfg_resv_a: assert property (
    (st_reg.cfg & ~`PCC_CFG_MASK) == 16'h0000)
    else $error("config reserved bits set");
  xtal_bits_a: assert property (
    (st_reg.xtal & ~`PCC_XTAL_MASK) == 16'h0000)
    else $error("crystal reserved bits set");
  mask_bits_a: assert property (
    (st_reg.irq_mask & ~`PCC_IRQ_MASKW) == 16'h0000)
    else $error("mask reserved bits set");

  lock_seen_c: cover property ($rose(pll_locked));
  frac_c: cover property (pll_locked && pll_frac_mode);
  switch_c: cover property (pll_locked ##1 $fell(clk_sel_pin));
  irq_c: cover property ($rose(irq));
  loss_c: cover property ($fell(pll_locked));

endmodule

/* verification/tb_pcc_regs.sv */
// Self-checking bench for the clock-control register block
`timescale 1ns/1ps
`include "pcc_defs.svh"
module tb_pcc_regs;
  localparam int         LK = 4;                  // Short lock keeps run brief
  localparam logic [1:0] OK = `PCC_RESP_OKAY;     // Normal response
  localparam logic [1:0] ER = `PCC_RESP_SLVERR;   // Unmapped response
  // Bus master side, all driven after rising edges
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
  logic [15:0] aw_a = 16'h0000, ar_a = 16'h0000;
  logic [31:0] w_d = 32'h0000_0000;
  logic [3:0]  w_s = 4'h0;
  // Slave answers and steering outputs
  logic        aw_k, w_k, b_v, ar_k, r_v, sel, en, frac, lck, irq;
  logic [1:0]  b_rs, r_rs, xt;
  logic [31:0] r_d;
  logic [4:0]  mul, pre;
  logic [15:0] num, den, d;
  // Bookkeeping
  int          miscompares = 0;
  int          checked = 0;
  logic [31:0] lf = 32'hc397;
  logic [11:0] idx_t [8] = '{`PCC_IDX_SRC, `PCC_IDX_DEN, `PCC_IDX_NUM,
    `PCC_IDX_CFG, `PCC_IDX_LOCK, `PCC_IDX_XTAL, `PCC_IDX_IRQ_STAT,
    `PCC_IDX_IRQ_MASK};

  // Free-running 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  pcc_regs #(.LOCK_CYC(LK)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_k), .s_axi_awaddr(aw_a),
    .s_axi_wvalid(w_v), .s_axi_wready(w_k), .s_axi_wdata(w_d),
    .s_axi_wstrb(w_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_bresp(b_rs), .s_axi_arvalid(ar_v), .s_axi_arready(ar_k),
    .s_axi_araddr(ar_a), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .clk_sel_pin(sel),
    .pll_enable(en), .pll_frac_mode(frac), .pll_multiplier(mul),
    .pll_prescale(pre), .frac_numerator(num), .frac_denominator(den),
    .crystal_ctrl(xt), .pll_locked(lck), .irq(irq));

  // Galois step for repeatable stimulus
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction
  // Readback keeps only the defined config fields
  function automatic logic [31:0] exp_cfg(input logic [15:0] v);
    return {16'h0000, v & 16'hf8f3};
  endfunction
  // Prescale divide is code plus one
  function automatic logic [4:0] exp_pre(input logic [15:0] v);
    return {1'b0, v[7:4]} + 5'h01;
  endfunction

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Let registered outputs settle before looking
  task settle;
    @(negedge ref_clk);
  endtask

  // One AXI write; handshakes sampled mid-cycle, acted on at the edge
  task wr(input logic [11:0] i, input logic [15:0] v, input logic [3:0] s,
          input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] rs;
    int n;
    tb = 1'b0;
    n = 0;
    @(posedge ref_clk);
    aw_a <= {2'b00, i, 2'b00};
    w_d  <= {lf[31:16], v};                  // Upper half must be ignored
    w_s  <= s;
    aw_v <= 1'b1;
    w_v  <= 1'b1;
    b_r  <= 1'b1;
    while (!tb && n < 50) begin
      @(negedge ref_clk);
      ta = aw_v && aw_k;
      tw = w_v && w_k;
      tb = b_v && b_r;
      rs = b_rs;
      @(posedge ref_clk);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
      if (tb) b_r <= 1'b0;
      n++;
    end
    chk(tb, 1'b1);
    chk(rs, er);
  endtask

  // One AXI read, data and response compared
  task rd(input logic [11:0] i, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] rv;
    logic [1:0] rs;
    int n;
    tr = 1'b0;
    n = 0;
    @(posedge ref_clk);
    ar_a <= {2'b00, i, 2'b00};
    ar_v <= 1'b1;
    r_r  <= 1'b1;
    while (!tr && n < 50) begin
      @(negedge ref_clk);
      ta = ar_v && ar_k;
      tr = r_v && r_r;
      rv = r_d;
      rs = r_rs;
      @(posedge ref_clk);
      if (ta) ar_v <= 1'b0;
      if (tr) r_r <= 1'b0;
      n++;
    end
    chk(tr, 1'b1);
    chk(rv, ed);
    chk(rs, er);
  endtask

  // Bounded wait for the lock model
  task wait_lock;
    int n;
    n = 0;
    while (lck !== 1'b1 && n < LK + 8) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  // Verdict and end of run
  task complete_run;
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    #200000;
    miscompares++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    settle;
    chk(sel, 1'b1);
    chk(pre, 5'h01);
    chk({en, frac, lck, irq}, 4'h0);
    for (int k = 0; k < 8; k++)
      rd(idx_t[k], (k == 0) ? 32'h1 : 32'h0, OK);
    // Field boundaries first, then random values
    for (int k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      d = (k == 0) ? 16'hffff : (k == 1) ? 16'h0001 : lf[15:0];
      wr(`PCC_IDX_DEN, d, 4'hf, OK);
      rd(`PCC_IDX_DEN, {16'h0, d}, OK);
      wr(`PCC_IDX_NUM, ~d, 4'hf, OK);
      rd(`PCC_IDX_NUM, {16'h0, ~d}, OK);
      wr(`PCC_IDX_CFG, d & 16'hfffe, 4'hf, OK);
      rd(`PCC_IDX_CFG, exp_cfg(d & 16'hfffe), OK);
      wr(`PCC_IDX_XTAL, d, 4'hf, OK);
      rd(`PCC_IDX_XTAL, {16'h0, d & `PCC_XTAL_MASK}, OK);
      settle;
      chk(mul, d[15:11]);
      chk(pre, exp_pre(d));
      chk(frac, d[1]);
      chk({en, lck}, 2'b00);
      chk({den, num}, {d, ~d});
      chk(xt, d[1:0]);
    end
    // Byte strobe, unmapped and read-only places
    wr(`PCC_IDX_DEN, 16'h0000, 4'hf, OK);
    wr(`PCC_IDX_DEN, 16'h5aa5, 4'h1, OK);
    rd(`PCC_IDX_DEN, 32'h0000_00a5, OK);
    wr(12'h004, 16'h1234, 4'hf, ER);
    wr(`PCC_IDX_LOCK, 16'h0001, 4'hf, OK);
    rd(`PCC_IDX_LOCK, 32'h0, OK);
    // Program, enable, lock, then leave bypass
    wr(`PCC_IDX_IRQ_MASK, `PCC_IRQ_MASKW, 4'hf, OK);
    rd(`PCC_IDX_IRQ_MASK, 32'h3, OK);
    wr(`PCC_IDX_NUM, 16'h0001, 4'hf, OK);
    wr(`PCC_IDX_DEN, 16'h0002, 4'hf, OK);
    wr(`PCC_IDX_CFG, 16'h0803, 4'hf, OK);
    wait_lock;
    chk({lck, irq}, 2'b11);
    rd(`PCC_IDX_LOCK, 32'h1, OK);
    rd(`PCC_IDX_IRQ_STAT, 32'h1, OK);
    settle;
    chk(irq, 1'b0);
    rd(`PCC_IDX_IRQ_STAT, 32'h0, OK);
    wr(`PCC_IDX_SRC, 16'h0000, 4'hf, OK);
    settle;
    chk(sel, 1'b0);
    // Disable drops lock and flags the loss
    wr(`PCC_IDX_CFG, 16'h0802, 4'hf, OK);
    settle;
    chk({lck, irq}, 2'b01);
    rd(`PCC_IDX_LOCK, 32'h0, OK);
    rd(`PCC_IDX_IRQ_STAT, 32'h2, OK);
    // Masked event stays off the line but is still recorded
    wr(`PCC_IDX_IRQ_MASK, 16'h0000, 4'hf, OK);
    wr(`PCC_IDX_CFG, 16'h0803, 4'hf, OK);
    wait_lock;
    chk({lck, irq}, 2'b10);
    rd(`PCC_IDX_IRQ_STAT, 32'h1, OK);
    wr(`PCC_IDX_SRC, 16'h0001, 4'hf, OK);
    settle;
    chk(sel, 1'b1);
    complete_run;
  end
endmodule
